// [clock_select_params.svh]
// constants for the clock source selection block
// Notes on behaviour
// - low-power oscillator gives the slow clock, running in suspend.
// - low-power oscillator may drive interval and capture timer clocks.
// - low-power oscillator has low-power and more accurate normal settings.
// - processor, USB, interval and capture clocks are selected separately.
// - processor clock from external or 24 MHz source, divided by 2^n.
// - USB engine clock is 12 MHz; halving stage allows a 24 MHz source.
// - interval clock picks one of four sources, prescaled by 1 to 4.
// - capture clock picks external, 24 MHz or low-power oscillator.
// - output pin shows filtered input, 24 MHz, low-power or cpu clock.
// - 24 MHz oscillator may lock to USB traffic for tight tolerance.
// - trim register: fine offset 7:5 (reset zero), gain 4:0.
// - gain has no meaningful reset; boot writes factory calibration.
// - speed codes 0..6 divide by 8,4,2,1,16,32,128; code 7 reserved.
// - USB source bit picks 24 MHz oscillator at 0, external at 1.
// - halving disable works only with external source.
`ifndef CLOCK_SELECT_PARAMS_SVH
`define CLOCK_SELECT_PARAMS_SVH
`define OFS_CLK_CFG 8'h30
`define OFS_OSC_TRIM 8'h34
`define OFS_TMR_SEL 8'h38
`define OFS_SPEED 8'h3c
`define OFS_STATUS 8'h40
`define POS_USB_HALF_DIS 6
`define POS_USB_SEL 5
`define POS_CPU_SEL 0
`define POS_FOFFSET 5
`define POS_GAIN 0
`define POS_ITMR_SRC 0
`define POS_ITMR_PRE 2
`define POS_CAP_SRC 4
`define POS_CLOCK_OUTPUT_PIN_SRC 6
`define POS_CLOCK_OUTPUT_PIN_EN 8
`define POS_FILTER_EN 9
`define POS_SPEED 0
`define POS_LP_LOW_POWER 3
`define RST_FOFFSET 3'h0
`define RST_GAIN 5'h10
`define RST_SPEED 3'h0
`define SPEED_RESERVED 3'h7
`endif

// [clock_select_pkg.sv]
// types shared by the clock source selection block
package clock_select_pkg;
	typedef struct packed {
		logic usb_half_dis;
		logic usb_sel;
		logic cpu_sel;
		logic [2:0] foffset;
		logic [4:0] gain;
		logic [1:0] itmr_src;
		logic [1:0] itmr_pre;
		logic [1:0] cap_src;
		logic [1:0] clock_output_pin_src;
		logic clock_output_pin_en;
		logic filter_en;
		logic [2:0] speed;
		logic lp_low_power;
	} clk_cfg_t;
	typedef enum logic [1:0] {SRC_EXT, SRC_OSC, SRC_LP, SRC_CPU} clock_output_pin_src_t;
endpackage : clock_select_pkg

// [tick_divider.sv]
// source-selecting tick divider that only retunes between output periods
`timescale 1ns/1ps
`default_nettype none
module tick_divider (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic [3:0] src_tick_i,
	input wire logic [1:0] sel_i,
	input wire logic [7:0] div_i,
	output logic tick_o
);
	logic [1:0] sel_ff;
	logic [7:0] div_ff;
	logic [7:0] cnt_ff;
	logic tick_ff;
	wire logic src = src_tick_i[sel_ff];
	wire logic wrap = src && (cnt_ff == div_ff - 8'h01);

	// new source and divisor are only taken with the count at rest
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sel_ff <= 2'h0;
			div_ff <= 8'h01;
			cnt_ff <= 8'h00;
			tick_ff <= 1'b0;
		end else begin
			if (cnt_ff == 8'h00 && !src) begin
				sel_ff <= sel_i;
				div_ff <= div_i;
			end
			if (wrap)
				cnt_ff <= 8'h00;
			else if (src)
				cnt_ff <= cnt_ff + 8'h01;
			tick_ff <= wrap;
		end
	end

	assign tick_o = tick_ff;
endmodule : tick_divider
`default_nettype wire

// [clock_source_selection.sv]
// clock source selection, division and oscillator trim with ahb-lite regs
`timescale 1ns/1ps
`default_nettype none
`include "clock_select_params.svh"
module clock_source_selection
	import clock_select_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic external_clock_input_i,
	input wire logic osc24_level_i,
	input wire logic lp_osc_level_i,
	input wire logic suspend_i,
	input wire logic usb_traffic_i,
	output logic processor_core_clock_o,
	output logic serial_bus_engine_clock_o,
	output logic interval_timer_clock_o,
	output logic capture_timer_clock_o,
	output logic slow_clock_o,
	output logic clock_output_pin_o,
	output logic clock_output_pin_oe_o,
	output logic [2:0] osc_foffset_o,
	output logic [4:0] osc_gain_o,
	output logic osc_usb_lock_o,
	output logic lp_low_power_o
);
	clk_cfg_t cfg_ff;
	logic [2:0] sync1_ff;
	logic [2:0] sync2_ff;
	logic [2:0] prev_ff;
	logic ext_filt_ff;
	logic ext_last_ff;
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic [31:0] rdata_ff;
	logic cpu_lvl_ff;
	logic [1:0] cur_src_ff;
	logic parked_ff;
	logic pin_ff;

	// external pin and both oscillators pass two flip-flops
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync1_ff <= 3'h0;
			sync2_ff <= 3'h0;
		end else begin
			sync1_ff <= {lp_osc_level_i, osc24_level_i, external_clock_input_i};
			sync2_ff <= sync1_ff;
		end
	end

	// transient filter: external level moves only after two equal samples
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ext_last_ff <= 1'b0;
			ext_filt_ff <= 1'b0;
			prev_ff <= 3'h0;
		end else begin
			ext_last_ff <= sync2_ff[0];
			if (!cfg_ff.filter_en || ext_last_ff == sync2_ff[0])
				ext_filt_ff <= sync2_ff[0];
			prev_ff <= {sync2_ff[2:1], ext_filt_ff};
		end
	end

	// rising edges of each source become one-cycle ticks
	wire logic ext_tick = ext_filt_ff & ~prev_ff[0];
	wire logic osc_tick = sync2_ff[1] & ~prev_ff[1];
	wire logic lp_tick = sync2_ff[2] & ~prev_ff[2];

	// processor speed code to divisor
	function automatic logic [7:0] speed_div(input logic [2:0] code);
		case (code)
			3'h0: speed_div = 8'h08;
			3'h1: speed_div = 8'h04;
			3'h2: speed_div = 8'h02;
			3'h3: speed_div = 8'h01;
			3'h4: speed_div = 8'h10;
			3'h5: speed_div = 8'h20;
			default: speed_div = 8'h80;
		endcase
	endfunction : speed_div

	// per-consumer source vectors, selects and divisors
	wire logic [3:0] cpu_srcs = {2'h0, ext_tick, osc_tick};
	wire logic [1:0] cpu_sel = {1'b0, cfg_ff.cpu_sel};
	wire logic [7:0] cpu_div = speed_div(cfg_ff.speed);
	wire logic [3:0] usb_srcs = {2'h0, ext_tick, osc_tick};
	wire logic [1:0] usb_sel = {1'b0, cfg_ff.usb_sel};
	wire logic usb_undiv = cfg_ff.usb_sel & cfg_ff.usb_half_dis;
	wire logic [7:0] usb_div = usb_undiv ? 8'h01 : 8'h02;
	wire logic [3:0] cap_srcs = {1'b0, lp_tick, osc_tick, ext_tick};
	wire logic [1:0] cap_sel = (cfg_ff.cap_src == 2'h3) ? 2'h2 :
		cfg_ff.cap_src;
	wire logic cap_tick;
	wire logic cpu_tick;
	wire logic [3:0] itmr_srcs = {cap_tick, lp_tick, osc_tick, ext_tick};
	wire logic [7:0] itmr_div = {6'h00, cfg_ff.itmr_pre} + 8'h01;

	// one divider per consumer clock
	tick_divider cpu_div_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.src_tick_i(cpu_srcs), .sel_i(cpu_sel), .div_i(cpu_div),
		.tick_o(cpu_tick));
	tick_divider usb_div_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.src_tick_i(usb_srcs), .sel_i(usb_sel), .div_i(usb_div),
		.tick_o(serial_bus_engine_clock_o));
	tick_divider cap_div_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.src_tick_i(cap_srcs), .sel_i(cap_sel), .div_i(8'h01),
		.tick_o(cap_tick));
	tick_divider itmr_div_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.src_tick_i(itmr_srcs), .sel_i(cfg_ff.itmr_src), .div_i(itmr_div),
		.tick_o(interval_timer_clock_o));

	// processor clock stops in suspend at processor_core_clock_o, not on the output pin; slow clock keeps running
	assign processor_core_clock_o = cpu_tick & ~suspend_i;
	assign capture_timer_clock_o = cap_tick;
	assign slow_clock_o = lp_tick;

	// clock output pin: park low on old source, resume on new one when low
	wire logic [3:0] out_lvls = {cpu_lvl_ff, sync2_ff[2], sync2_ff[1],
		ext_filt_ff};
	wire logic switch_req = cfg_ff.clock_output_pin_src != cur_src_ff;
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cpu_lvl_ff <= 1'b0;
			cur_src_ff <= 2'h0;
			parked_ff <= 1'b0;
			pin_ff <= 1'b0;
		end else begin
			if (cpu_tick)
				cpu_lvl_ff <= ~cpu_lvl_ff;
			if (!parked_ff && switch_req && !out_lvls[cur_src_ff])
				parked_ff <= 1'b1;
			else if (parked_ff && !out_lvls[cfg_ff.clock_output_pin_src]) begin
				parked_ff <= 1'b0;
				cur_src_ff <= cfg_ff.clock_output_pin_src;
			end
			pin_ff <= parked_ff ? 1'b0 : out_lvls[cur_src_ff];
		end
	end
	assign clock_output_pin_o = pin_ff;
	assign clock_output_pin_oe_o = cfg_ff.clock_output_pin_en;

	// oscillator controls
	assign osc_foffset_o = cfg_ff.foffset;
	assign osc_gain_o = cfg_ff.gain;
	assign osc_usb_lock_o = usb_traffic_i & ~cfg_ff.usb_sel;
	assign lp_low_power_o = cfg_ff.lp_low_power;

	// ahb-lite address phase decode
	wire logic addr_ok = hsel & hready & htrans[1];
	wire logic [7:0] a_ofs = haddr[7:0];
	wire logic a_hit = (haddr[31:8] == 24'h000000) && (a_ofs[1:0] == 2'h0);
	wire logic [31:0] rd_cfg = {25'h0, cfg_ff.usb_half_dis, cfg_ff.usb_sel,
		4'h0, cfg_ff.cpu_sel};
	wire logic [31:0] rd_trim = {24'h0, cfg_ff.foffset, cfg_ff.gain};
	wire logic [31:0] rd_tmr = {22'h0, cfg_ff.filter_en, cfg_ff.clock_output_pin_en,
		cfg_ff.clock_output_pin_src, cfg_ff.cap_src, cfg_ff.itmr_pre, cfg_ff.itmr_src};
	wire logic [31:0] rd_speed = {28'h0, cfg_ff.lp_low_power, cfg_ff.speed};
	wire logic [31:0] rd_status = {23'h0, parked_ff, cur_src_ff, ext_filt_ff,
		osc_usb_lock_o, suspend_i, cfg_ff.speed};
	wire logic [31:0] rd_mux =
		!a_hit ? 32'h0 :
		(a_ofs == `OFS_CLK_CFG) ? rd_cfg :
		(a_ofs == `OFS_OSC_TRIM) ? rd_trim :
		(a_ofs == `OFS_TMR_SEL) ? rd_tmr :
		(a_ofs == `OFS_SPEED) ? rd_speed :
		(a_ofs == `OFS_STATUS) ? rd_status : 32'h0;

	// latch write address and read data at the end of the address phase
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			rdata_ff <= 32'h0;
		end else begin
			wr_pend_ff <= addr_ok & hwrite & a_hit;
			if (addr_ok) begin
				wr_addr_ff <= a_ofs;
				rdata_ff <= hwrite ? 32'h0 : rd_mux;
			end
		end
	end

	// register writes in the data phase; reserved speed code is refused
	wire logic [2:0] wr_speed = hwdata[`POS_SPEED +: 3];
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cfg_ff <= '0;
			cfg_ff.foffset <= `RST_FOFFSET;
			cfg_ff.gain <= `RST_GAIN;
			cfg_ff.speed <= `RST_SPEED;
		end else if (wr_pend_ff) begin
			if (wr_addr_ff == `OFS_CLK_CFG) begin
				cfg_ff.usb_half_dis <= hwdata[`POS_USB_HALF_DIS];
				cfg_ff.usb_sel <= hwdata[`POS_USB_SEL];
				cfg_ff.cpu_sel <= hwdata[`POS_CPU_SEL];
			end else if (wr_addr_ff == `OFS_OSC_TRIM) begin
				cfg_ff.foffset <= hwdata[`POS_FOFFSET +: 3];
				cfg_ff.gain <= hwdata[`POS_GAIN +: 5];
			end else if (wr_addr_ff == `OFS_TMR_SEL) begin
				cfg_ff.itmr_src <= hwdata[`POS_ITMR_SRC +: 2];
				cfg_ff.itmr_pre <= hwdata[`POS_ITMR_PRE +: 2];
				cfg_ff.cap_src <= hwdata[`POS_CAP_SRC +: 2];
				cfg_ff.clock_output_pin_src <= hwdata[`POS_CLOCK_OUTPUT_PIN_SRC +: 2];
				cfg_ff.clock_output_pin_en <= hwdata[`POS_CLOCK_OUTPUT_PIN_EN];
				cfg_ff.filter_en <= hwdata[`POS_FILTER_EN];
			end else if (wr_addr_ff == `OFS_SPEED) begin
				if (wr_speed != `SPEED_RESERVED)
					cfg_ff.speed <= wr_speed;
				cfg_ff.lp_low_power <= hwdata[`POS_LP_LOW_POWER];
			end
		end
	end

	// zero-wait slave, always okay
	assign hrdata = rdata_ff;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
endmodule : clock_source_selection
`default_nettype wire

// [clock_source_selection_assertions.sv]
// checker for the clock source selection block
`timescale 1ns/1ps
`default_nettype none
module clock_source_selection_assertions (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic lp_osc_level_i,
	input wire logic suspend_i,
	input wire logic usb_traffic_i,
	input wire logic processor_core_clock_o,
	input wire logic serial_bus_engine_clock_o,
	input wire logic capture_timer_clock_o,
	input wire logic slow_clock_o,
	input wire logic [2:0] osc_foffset_o,
	input wire logic [4:0] osc_gain_o,
	input wire logic osc_usb_lock_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	logic wr_ff;
	logic [7:0] wd_ff;
	// remember a trim write address phase and the data phase word
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_ff <= 1'b0;
			wd_ff <= 8'h00;
		end else begin
			wr_ff <= hsel && hready && htrans[1] && hwrite && haddr == 32'h34;
			wd_ff <= hwdata[7:0];
		end
	end
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	a_lock_traffic: assert property (
		!usb_traffic_i |-> !osc_usb_lock_o)
		else $error("oscillator locked without traffic");
	a_suspend_gate: assert property (
		suspend_i |-> !processor_core_clock_o)
		else $error("processor tick during suspend");
	a_slow_follow: assert property (
		$rose(lp_osc_level_i) |-> ##[1:5] slow_clock_o)
		else $error("slow tick missing");
	a_trim_reset: assert property (
		$rose(reset_n_i) |-> osc_foffset_o == 3'h0)
		else $error("fine offset not zero after reset");
	a_trim_write: assert property (
		wr_ff |=> {osc_foffset_o, osc_gain_o} == wd_ff)
		else $error("trim outputs do not follow write");
	a_cpu_pulse: assert property (
		processor_core_clock_o |=> !processor_core_clock_o)
		else $error("processor tick too long");
	a_usb_pulse: assert property (
		serial_bus_engine_clock_o |=> !serial_bus_engine_clock_o)
		else $error("usb tick too long");
	a_cap_pulse: assert property (
		capture_timer_clock_o |=> !capture_timer_clock_o)
		else $error("capture tick too long");
endmodule : clock_source_selection_assertions
bind clock_source_selection clock_source_selection_assertions u_chk (
	.clock_i(clock_i), .reset_n_i(reset_n_i), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .lp_osc_level_i(lp_osc_level_i),
	.suspend_i(suspend_i), .usb_traffic_i(usb_traffic_i),
	.processor_core_clock_o(processor_core_clock_o),
	.serial_bus_engine_clock_o(serial_bus_engine_clock_o),
	.capture_timer_clock_o(capture_timer_clock_o),
	.slow_clock_o(slow_clock_o), .osc_foffset_o(osc_foffset_o),
	.osc_gain_o(osc_gain_o), .osc_usb_lock_o(osc_usb_lock_o));
`default_nettype wire

// [clock_consumer_model.sv]
// tick consumers standing behind the clock outputs
`timescale 1ns/1ps
`default_nettype none
module clock_consumer_model (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic cpu_tick_i,
	input wire logic itmr_tick_i,
	output logic [15:0] cpu_count_o,
	output logic [15:0] itmr_read_o
);
	logic [15:0] cnt_ff;
	logic [15:0] first_ff;
	// processor counts its periods, interval counter counts its ticks
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cpu_count_o <= 16'h0000;
			cnt_ff <= 16'h0000;
			first_ff <= 16'h0000;
			itmr_read_o <= 16'h0000;
		end else begin
			cpu_count_o <= cpu_count_o + {15'h0000, cpu_tick_i};
			cnt_ff <= cnt_ff + {15'h0000, itmr_tick_i};
			first_ff <= cnt_ff;
			// a reading is kept only when two successive reads agree
			if (first_ff == cnt_ff) itmr_read_o <= cnt_ff;
		end
	end
endmodule : clock_consumer_model
`default_nettype wire

// [clock_source_selection_tb_top.sv]
// self-checking bench for the clock source selection block
`timescale 1ns/1ps
`default_nettype none
module clock_source_selection_tb_top;
	logic clock_i, reset_n_i, hsel, hwrite, ext_i, osc_i, lp_i;
	logic suspend_i, traffic_i;
	logic [31:0] haddr, hwdata, rv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	wire logic hrdy, hresp, oe, lock, lpm, slow;
	wire logic [31:0] hrdata;
	wire logic [4:0] tk;
	wire logic [2:0] fo;
	wire logic [4:0] gn;
	wire logic [15:0] cpu_cnt, itmr_rd;
	int mismatches, check_count, k;
	clock_source_selection u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
		.hreadyout(hrdy), .hresp(hresp), .external_clock_input_i(ext_i),
		.osc24_level_i(osc_i), .lp_osc_level_i(lp_i), .suspend_i(suspend_i),
		.usb_traffic_i(traffic_i), .processor_core_clock_o(tk[0]),
		.serial_bus_engine_clock_o(tk[1]), .interval_timer_clock_o(tk[2]),
		.capture_timer_clock_o(tk[3]), .slow_clock_o(slow),
		.clock_output_pin_o(tk[4]), .clock_output_pin_oe_o(oe),
		.osc_foffset_o(fo), .osc_gain_o(gn), .osc_usb_lock_o(lock),
		.lp_low_power_o(lpm));
	clock_consumer_model u_consumer (.clock_i(clock_i),
		.reset_n_i(reset_n_i), .cpu_tick_i(tk[0]), .itmr_tick_i(tk[2]),
		.cpu_count_o(cpu_cnt), .itmr_read_o(itmr_rd));
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	// oscillator periods of 10, ext 14, low-power 100 cycles
	always @(posedge clock_i) begin
		k <= k + 1;
		osc_i <= (k % 10) < 5;
		ext_i <= (k % 14) < 7;
		lp_i <= (k % 100) < 50;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// one single-word transfer, read data left in rv
	task automatic ahb(input logic w, input logic [31:0] a, d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clock_i); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock_i); while (hrdy !== 1'b1);
		rv = hrdata;
	endtask : ahb
	// skips retune periods, then checks rise-to-rise distance
	task automatic per(input int i, input int e);
		int n;
		logic p, c;
		repeat (4) begin
			n = 0;
			c = tk[i];
			do begin
				p = c;
				@(posedge clock_i);
				#1 c = tk[i];
				n++;
			end while (!(c && !p) && n < 3000);
		end
		check(n, e);
	endtask : per
	task automatic t_reset;
		ahb(0, 32'h34, 0);
		check(rv, 32'h10);
		ahb(0, 32'h44, 0);
		check(rv, 32'h0);
		per(0, 80);
		ahb(1, 32'h34, 32'hffffff5a);
		ahb(0, 32'h34, 0);
		check(rv, 32'h5a);
		check({fo, gn}, 8'h5a);
	endtask : t_reset
	task automatic t_speed;
		int dv[7] = '{8, 4, 2, 1, 16, 32, 128};
		for (int c = 0; c < 7; c++) begin
			ahb(1, 32'h3c, c);
			per(0, 10 * dv[c]);
		end
		ahb(1, 32'h3c, 32'h3);
		ahb(1, 32'h3c, 32'hf);
		ahb(0, 32'h3c, 0);
		check(rv, 32'hb);
		check(lpm, 1'b1);
		per(0, 10);
		ahb(1, 32'h30, 32'h1);
		per(0, 14);
	endtask : t_speed
	task automatic t_usb;
		int cf[4] = '{32'h60, 32'h20, 32'h40, 32'h0};
		int ex[4] = '{14, 28, 20, 20};
		traffic_i <= 1'b1;
		// cpu stays at speed code 3, far above usb/8
		for (int i = 0; i < 4; i++) begin
			ahb(1, 32'h30, cf[i]);
			per(1, ex[i]);
			check(lock, i > 1);
		end
		traffic_i <= 1'b0;
	endtask : t_usb
	task automatic t_timers;
		int cf[15] = '{1, 5, 9, 13, 0, 2, 0, 16, 32, 39, 256, 320, 384, 448,
			768};
		int ix[15] = '{2, 2, 2, 2, 2, 2, 3, 3, 3, 2, 4, 4, 4, 4, 4};
		int ex[15] = '{10, 20, 30, 40, 14, 100, 14, 10, 100, 200, 14, 10,
			100, 20, 14};
		logic [15:0] a;
		for (int i = 0; i < 15; i++) begin
			ahb(1, 32'h38, cf[i]);
			per(ix[i], ex[i]);
		end
		// settled reading grows by one per interval tick
		for (int j = 0; j < 2; j++) begin
			do begin
				@(posedge clock_i);
				#1;
			end while (tk[2] !== 1'b1);
			repeat (3) @(posedge clock_i);
			#1;
			if (j == 0)
				a = itmr_rd;
		end
		check(itmr_rd, a + 16'h0001);
		@(posedge clock_i);
		check(oe, 1'b1);
	endtask : t_timers
	task automatic t_suspend;
		logic [15:0] c0;
		suspend_i <= 1'b1;
		ahb(0, 32'h40, 0);
		check(rv[3], 1'b1);
		c0 = cpu_cnt;
		repeat (50) @(posedge clock_i);
		check(cpu_cnt, c0);
		suspend_i <= 1'b0;
		per(0, 10);
	endtask : t_suspend
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	initial begin
		{k, mismatches, check_count} = '0;
		{hsel, hwrite, haddr, hwdata, htrans, suspend_i, traffic_i} = '0;
		{ext_i, osc_i, lp_i} = '0;
		hsize = 3'h2;
		reset_n_i = 1'b0;
		repeat (4) @(posedge clock_i);
		reset_n_i <= 1'b1;
		t_reset;
		t_speed;
		t_usb;
		t_timers;
		t_suspend;
		final_report;
	end
	// watchdog well beyond the expected run length
	initial begin
		#300000;
		mismatches++;
		final_report;
	end
endmodule : clock_source_selection_tb_top
`default_nettype wire
